// *** common/cpcp_pkg.sv ***
// Purpose: Shared constants for the cell processor command port.
// Assumes: One system clock, 32-bit register words.
// Notes: Field positions follow the command word layout.
package cpcp_pkg;
    // Register selects on the command port.
    localparam logic [1:0] SEL_CMD = 2'h0;
    localparam logic [1:0] SEL_EXT = 2'h1;
    localparam logic [1:0] SEL_INBAR = 2'h2;
    localparam logic [1:0] SEL_IBBAR = 2'h3;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
    // Command word fields.
    localparam int OP_LSB = 26;
    localparam int BUSY_BIT = 25;
    localparam int ERR_BIT = 24;
    localparam int IA_RW_BIT = 23;
    localparam int IA_BE_LSB = 19;
    localparam int DIR_BIT = 18;
    localparam int POOL_LSB = 16;
    localparam int VC_LSB = 6;
    localparam int VC_W = 12;
    localparam int IA_ADDR_W = 19;
    localparam logic [5:0] OP_LINK = 6'h01;
    localparam logic [5:0] OP_OPEN = 6'h02;
    localparam logic [5:0] OP_CLOSE = 6'h03;
    localparam logic [5:0] OP_TXRDY = 6'h04;
    localparam logic [5:0] OP_INDIR = 6'h05;
    localparam logic [5:0] OP_ADDBUF = 6'h1A;
    // Resource sizes.
    localparam int NUM_VC = 64;
    localparam int NUM_POOL = 8;
    localparam logic [16:0] CNT_MAX = 17'h0FFFF;
    localparam logic [1:0] POOL_HI_ZERO = 2'h0;
    // Instruction space.
    localparam int ISPACE_W = 20;
    localparam logic [19:0] BOOT_ADDR = 20'h00000;
    localparam logic [19:0] IRAM_BYTES = 20'h02000;
    localparam logic [10:0] IRAM_LAST = 11'h7FF;
    // Control memory window inside the indirect address space.
    localparam int CTRL_SEL_BIT = 18;
    localparam int WRAM_AW = 14;
endpackage

// *** common/cpcp_if.sv ***
// Purpose: Register pins between host and cell processor command port.
// Assumes: Both ends run on clk_sys.
// Notes: Read data returns one cycle after reg_rd.
`timescale 1ns/100ps
interface cpcp_if;
    logic reg_wr;
    logic reg_rd;
    logic [1:0] reg_sel;
    logic [31:0] reg_wdata;
    logic [31:0] reg_rdata;
    logic reg_rvalid;
    logic cp_start;
    modport dev (
        input reg_wr, reg_rd, reg_sel, reg_wdata, cp_start,
        output reg_rdata, reg_rvalid
    );
    modport host (
        output reg_wr, reg_rd, reg_sel, reg_wdata, cp_start,
        input reg_rdata, reg_rvalid
    );
endinterface

// *** verilog/cpcp_dev.sv ***
// Purpose: Command interpreter and firmware start-up of the cell processor.
// Assumes: Host keeps the busy handshake; memories answer with ack pulses.
// Notes: One command is processed at a time.
`timescale 1ns/100ps
//
// Contract
// - Rx buffers any length, any byte address
// - 1 MB instruction space, 8 KB RAM
// - Fetch address plus instruction base register
// - Host loads firmware, bases, then starts
// - First boot fetch stalls core, copies block
// - Low 8 KB from RAM, rest cache
// - Busy set on accept, cleared when done
// - Host writes command only when not busy
// - Indication written; host reads after busy
// - Extension captured at command write
// - Host reads extension after busy clears
// - Host issues link rate exactly once
// - Open reserves VC, zero when full
// - Close frees VC, echoes or zero
// - Error bit 24 set on error
// - Tx ready activates scheduling, echoes VC
// - Pool refill opcode and field layout
// - Host writes pool bits 20:19 zero
// - Refill error above 65535, echo pool
// - Indirect access direction and byte lanes
// - Word aligned address, control memory converted
module cpcp_dev (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rst_b,
    // Host register pins.
    cpcp_if.dev bus,
    // Core instruction fetch.
    input wire logic core_fetch_req,
    input wire logic [cpcp_pkg::ISPACE_W-1:0] core_fetch_addr,
    output logic [31:0] fetch_sys_addr,
    output logic fetch_from_iram,
    output logic core_stall,
    // Boot copy from system memory into instruction RAM.
    output logic imem_req,
    output logic [31:0] imem_addr,
    input wire logic imem_ack,
    input wire logic [31:0] imem_rdata,
    output logic iram_we,
    output logic [10:0] iram_idx,
    output logic [31:0] iram_wdata,
    // Work RAM access.
    output logic wram_req,
    output logic wram_we,
    output logic [3:0] wram_be,
    output logic [cpcp_pkg::IA_ADDR_W-1:0] wram_addr,
    output logic [31:0] wram_wdata,
    input wire logic wram_ack,
    input wire logic [31:0] wram_rdata,
    // Events towards the rest of the cell processor.
    output logic [31:0] shared_base,
    output logic [25:0] link_rate_cfg,
    output logic sched_start,
    output logic [5:0] sched_vc,
    output logic pool_add,
    output logic [2:0] pool_num,
    output logic [15:0] pool_cnt,
    output logic [31:0] pool_ptr
);
    import cpcp_pkg::*;

    typedef enum logic [2:0] {
        D_IDLE = 3'b001,
        D_EXEC = 3'b010,
        D_WRAM = 3'b100
    } cpcp_dst_t;
    typedef enum logic [2:0] {
        B_WAIT = 3'b001,
        B_COPY = 3'b010,
        B_RUN = 3'b100
    } cpcp_bst_t;

    cpcp_dst_t dst_r;
    cpcp_bst_t bst_r;
    logic busy_r, started_r;
    logic [31:0] cmd_r, ext_r, ext_cap_r, inbar_r, ibbar_r;
    logic [NUM_VC-1:0] alloc_r;
    logic [15:0] cnt_r [NUM_POOL];
    logic [10:0] boot_idx_r;
    logic [5:0] op;
    logic [11:0] vc;
    logic [2:0] pool;
    logic [16:0] sum;
    logic [5:0] free_vc;
    logic cmd_wr, ia_read;

    function automatic logic vc_ok(input logic [11:0] v,
                                   input logic [NUM_VC-1:0] m);
        return (v != 12'h000) && (v < 12'(NUM_VC)) && m[v[5:0]];
    endfunction

    function automatic logic [5:0] find_free(input logic [NUM_VC-1:0] m);
        find_free = 6'h00;
        for (int i = NUM_VC - 1; i >= 1; i--) begin
            if (!m[i]) find_free = 6'(i);
        end
    endfunction

    // A write during busy must not disturb the running command.
    assign cmd_wr = bus.reg_wr && (bus.reg_sel == SEL_CMD) && !busy_r;
    assign op = cmd_r[OP_LSB +: 6];
    assign vc = cmd_r[VC_LSB +: VC_W];
    assign pool = cmd_r[POOL_LSB +: 3];
    assign ia_read = cmd_r[IA_RW_BIT];
    assign free_vc = find_free(alloc_r);
    assign sum = {1'b0, cnt_r[pool]} + {1'b0, cmd_r[15:0]};

    // Host register writes and indications.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cmd_r <= RESET_WORD;
            ext_r <= RESET_WORD;
            ext_cap_r <= RESET_WORD;
            inbar_r <= RESET_WORD;
            ibbar_r <= RESET_WORD;
        end else begin
            if (bus.reg_wr && bus.reg_sel == SEL_EXT) begin
                ext_r <= bus.reg_wdata;
            end
            if (bus.reg_wr && bus.reg_sel == SEL_INBAR) begin
                inbar_r <= bus.reg_wdata;
            end
            if (bus.reg_wr && bus.reg_sel == SEL_IBBAR) begin
                ibbar_r <= bus.reg_wdata;
            end
            if (cmd_wr) begin
                cmd_r <= bus.reg_wdata;
                // Later extension writes cannot reach this command.
                ext_cap_r <= ext_r;
            end
            if (dst_r == D_EXEC) begin
                unique case (op)
                    OP_OPEN: begin
                        // Zero VC means no channel left.
                        cmd_r[VC_LSB +: VC_W] <= {6'h00, free_vc};
                        cmd_r[ERR_BIT] <= 1'b0;
                    end
                    OP_CLOSE: begin
                        // Echo on success, zero on failure.
                        cmd_r[VC_LSB +: VC_W] <= vc_ok(vc, alloc_r) ?
                            vc : 12'h000;
                        cmd_r[ERR_BIT] <= !vc_ok(vc, alloc_r);
                    end
                    OP_TXRDY: begin
                        cmd_r[ERR_BIT] <= !vc_ok(vc, alloc_r);
                    end
                    OP_ADDBUF: begin
                        // Pool number stays in place as the echo.
                        cmd_r[ERR_BIT] <= (sum > CNT_MAX) ||
                            (cmd_r[20:19] != POOL_HI_ZERO);
                    end
                    default: ;
                endcase
            end
            if (dst_r == D_WRAM && wram_ack && ia_read) begin
                ext_r <= wram_rdata;
            end
        end
    end

    // Command sequencer and busy flag.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            dst_r <= D_IDLE;
            busy_r <= 1'b0;
        end else begin
            unique case (dst_r)
                D_IDLE: begin
                    if (cmd_wr) begin
                        dst_r <= D_EXEC;
                        busy_r <= 1'b1;
                    end
                end
                D_EXEC: begin
                    if (op == OP_INDIR) begin
                        dst_r <= D_WRAM;
                    end else begin
                        dst_r <= D_IDLE;
                        busy_r <= 1'b0;
                    end
                end
                D_WRAM: begin
                    if (wram_ack) begin
                        dst_r <= D_IDLE;
                        busy_r <= 1'b0;
                    end
                end
                default: begin
                    dst_r <= D_IDLE;
                    busy_r <= 1'b0;
                end
            endcase
        end
    end

    // Channel table, pool counts and events.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            alloc_r <= '0;
            for (int i = 0; i < NUM_POOL; i++) begin
                cnt_r[i] <= 16'h0000;
            end
            link_rate_cfg <= 26'h0000000;
            sched_start <= 1'b0;
            sched_vc <= 6'h00;
            pool_add <= 1'b0;
            pool_num <= 3'h0;
            pool_cnt <= 16'h0000;
            pool_ptr <= RESET_WORD;
        end else begin
            sched_start <= 1'b0;
            pool_add <= 1'b0;
            if (dst_r == D_EXEC) begin
                unique case (op)
                    OP_LINK: link_rate_cfg <= cmd_r[25:0];
                    OP_OPEN: begin
                        if (free_vc != 6'h00) begin
                            alloc_r[free_vc] <= 1'b1;
                        end
                    end
                    OP_CLOSE: begin
                        if (vc_ok(vc, alloc_r)) begin
                            alloc_r[vc[5:0]] <= 1'b0;
                        end
                    end
                    OP_TXRDY: begin
                        sched_start <= vc_ok(vc, alloc_r);
                        sched_vc <= vc[5:0];
                    end
                    OP_ADDBUF: begin
                        if (sum <= CNT_MAX && cmd_r[20:19] == POOL_HI_ZERO)
                        begin
                            cnt_r[pool] <= sum[15:0];
                            pool_add <= 1'b1;
                            pool_num <= pool;
                            pool_cnt <= cmd_r[15:0];
                            // Directory pointer is taken at any byte.
                            pool_ptr <= ext_cap_r;
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    // Indirect Work RAM access.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            wram_req <= 1'b0;
            wram_we <= 1'b0;
            wram_be <= 4'h0;
            wram_addr <= '0;
            wram_wdata <= RESET_WORD;
        end else begin
            if (dst_r == D_EXEC && op == OP_INDIR) begin
                wram_req <= 1'b1;
                wram_we <= !ia_read;
                wram_be <= ia_read ? 4'hF : cmd_r[IA_BE_LSB +: 4];
                wram_wdata <= ext_cap_r;
                // Control memory maps onto internal offsets.
                wram_addr <= cmd_r[CTRL_SEL_BIT] ?
                    {5'h00, cmd_r[WRAM_AW-1:2], 2'h0} :
                    {cmd_r[IA_ADDR_W-1:2], 2'h0};
            end else if (wram_ack) begin
                wram_req <= 1'b0;
            end
        end
    end

    // Register reads are registered and never touch state.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            bus.reg_rdata <= RESET_WORD;
            bus.reg_rvalid <= 1'b0;
        end else begin
            bus.reg_rvalid <= bus.reg_rd;
            if (bus.reg_rd) begin
                unique case (bus.reg_sel)
                    SEL_CMD: begin
                        bus.reg_rdata <= cmd_r;
                        bus.reg_rdata[BUSY_BIT] <= busy_r;
                    end
                    SEL_EXT: bus.reg_rdata <= ext_r;
                    SEL_INBAR: bus.reg_rdata <= inbar_r;
                    SEL_IBBAR: bus.reg_rdata <= ibbar_r;
                endcase
            end
        end
    end

    // Firmware start-up: the first boot fetch triggers the RAM fill.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            bst_r <= B_WAIT;
            started_r <= 1'b0;
            boot_idx_r <= 11'h000;
            imem_req <= 1'b0;
            imem_addr <= RESET_WORD;
            iram_we <= 1'b0;
            iram_idx <= 11'h000;
            iram_wdata <= RESET_WORD;
        end else begin
            iram_we <= 1'b0;
            if (bus.cp_start) begin
                started_r <= 1'b1;
            end
            unique case (bst_r)
                B_WAIT: begin
                    if (started_r && core_fetch_req &&
                        core_fetch_addr == BOOT_ADDR) begin
                        bst_r <= B_COPY;
                        imem_req <= 1'b1;
                        imem_addr <= inbar_r;
                    end
                end
                B_COPY: begin
                    if (imem_ack) begin
                        iram_we <= 1'b1;
                        iram_idx <= boot_idx_r;
                        iram_wdata <= imem_rdata;
                        boot_idx_r <= boot_idx_r + 11'h001;
                        imem_addr <= imem_addr + 32'h0000_0004;
                        if (boot_idx_r == IRAM_LAST) begin
                            bst_r <= B_RUN;
                            imem_req <= 1'b0;
                        end
                    end
                end
                B_RUN: ;
                default: begin
                    bst_r <= B_WAIT;
                end
            endcase
        end
    end

    assign core_stall = (bst_r != B_RUN);
    assign shared_base = ibbar_r;

    // Fetch translation for a 20-bit instruction space.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            fetch_sys_addr <= RESET_WORD;
            fetch_from_iram <= 1'b0;
        end else if (core_fetch_req) begin
            fetch_sys_addr <= inbar_r + {12'h000, core_fetch_addr};
            fetch_from_iram <= core_fetch_addr < IRAM_BYTES;
        end
    end
endmodule

// *** verilog/cpcp_host.sv ***
// Purpose: Host end that drives commands into the cell processor port.
// Assumes: Firmware is already in system memory before init is requested.
// Notes: Polls the busy flag; it never writes a command while busy.
`timescale 1ns/100ps
module cpcp_host (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rst_b,
    // Device register pins.
    cpcp_if.host bus,
    // Initialisation request.
    input wire logic usr_init_req,
    input wire logic [31:0] usr_inbar,
    input wire logic [31:0] usr_ibbar,
    // Command request and answer.
    input wire logic usr_cmd_req,
    input wire logic [31:0] usr_cmd_word,
    input wire logic [31:0] usr_ext_word,
    input wire logic usr_use_ext,
    output logic usr_ready,
    output logic usr_done,
    output logic usr_refused,
    output logic [31:0] usr_ind_word,
    output logic [31:0] usr_ext_rdata
);
    import cpcp_pkg::*;

    typedef enum logic [8:0] {
        H_IDLE = 9'b000000001,
        H_WIB = 9'b000000010,
        H_WSB = 9'b000000100,
        H_WEXT = 9'b000001000,
        H_WCMD = 9'b000010000,
        H_POLL = 9'b000100000,
        H_PWAIT = 9'b001000000,
        H_REXT = 9'b010000000,
        H_EWAIT = 9'b100000000
    } cpcp_hst_t;

    cpcp_hst_t st_r;
    logic link_set_r;
    logic [31:0] cmd_r, ext_r, ibbar_r;
    logic [31:0] cmd_nxt;
    logic [5:0] req_op;
    logic bad_req;

    assign req_op = usr_cmd_word[OP_LSB +: 6];
    // Link rate goes exactly once and before any transmit.
    assign bad_req = (req_op == OP_LINK && link_set_r) ||
        (req_op == OP_TXRDY && !link_set_r);
    assign usr_ready = (st_r == H_IDLE);

    always_comb begin
        cmd_nxt = usr_cmd_word;
        cmd_nxt[BUSY_BIT] = 1'b0;
        cmd_nxt[ERR_BIT] = 1'b0;
        if (req_op == OP_ADDBUF) begin
            cmd_nxt[20:19] = POOL_HI_ZERO;
        end
        if (req_op == OP_INDIR) begin
            cmd_nxt[1:0] = 2'h0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= H_IDLE;
            link_set_r <= 1'b0;
            cmd_r <= RESET_WORD;
            ext_r <= RESET_WORD;
            ibbar_r <= RESET_WORD;
            usr_done <= 1'b0;
            usr_refused <= 1'b0;
            usr_ind_word <= RESET_WORD;
            usr_ext_rdata <= RESET_WORD;
            bus.reg_wr <= 1'b0;
            bus.reg_rd <= 1'b0;
            bus.reg_sel <= SEL_CMD;
            bus.reg_wdata <= RESET_WORD;
            bus.cp_start <= 1'b0;
        end else begin
            usr_done <= 1'b0;
            usr_refused <= 1'b0;
            bus.reg_wr <= 1'b0;
            bus.reg_rd <= 1'b0;
            bus.cp_start <= 1'b0;
            unique case (st_r)
                H_IDLE: begin
                    if (usr_init_req) begin
                        // Bases first, start last.
                        bus.reg_wr <= 1'b1;
                        bus.reg_sel <= SEL_INBAR;
                        bus.reg_wdata <= usr_inbar;
                        ibbar_r <= usr_ibbar;
                        st_r <= H_WIB;
                    end else if (usr_cmd_req && bad_req) begin
                        usr_refused <= 1'b1;
                    end else if (usr_cmd_req) begin
                        cmd_r <= cmd_nxt;
                        ext_r <= usr_ext_word;
                        link_set_r <= link_set_r || (req_op == OP_LINK);
                        // Check busy before the first write.
                        bus.reg_rd <= 1'b1;
                        bus.reg_sel <= SEL_CMD;
                        st_r <= usr_use_ext ? H_WEXT : H_WCMD;
                    end
                end
                H_WIB: begin
                    bus.reg_wr <= 1'b1;
                    bus.reg_sel <= SEL_IBBAR;
                    bus.reg_wdata <= ibbar_r;
                    st_r <= H_WSB;
                end
                H_WSB: begin
                    bus.cp_start <= 1'b1;
                    usr_done <= 1'b1;
                    st_r <= H_IDLE;
                end
                H_WEXT: begin
                    if (bus.reg_rvalid && bus.reg_rdata[BUSY_BIT]) begin
                        bus.reg_rd <= 1'b1;
                    end else if (bus.reg_rvalid) begin
                        // Extension goes before the command.
                        bus.reg_wr <= 1'b1;
                        bus.reg_sel <= SEL_EXT;
                        bus.reg_wdata <= ext_r;
                        st_r <= H_WCMD;
                    end
                end
                H_WCMD: begin
                    if (bus.reg_rvalid && bus.reg_rdata[BUSY_BIT]) begin
                        bus.reg_rd <= 1'b1;
                    end else if (bus.reg_rvalid || bus.reg_sel == SEL_EXT)
                    begin
                        bus.reg_wr <= 1'b1;
                        bus.reg_sel <= SEL_CMD;
                        bus.reg_wdata <= cmd_r;
                        st_r <= H_POLL;
                    end
                end
                H_POLL: begin
                    bus.reg_rd <= 1'b1;
                    st_r <= H_PWAIT;
                end
                H_PWAIT: begin
                    if (bus.reg_rvalid && bus.reg_rdata[BUSY_BIT]) begin
                        st_r <= H_POLL;
                    end else if (bus.reg_rvalid) begin
                        // Indication only counts once busy is clear.
                        usr_ind_word <= bus.reg_rdata;
                        st_r <= H_REXT;
                    end
                end
                H_REXT: begin
                    bus.reg_rd <= 1'b1;
                    bus.reg_sel <= SEL_EXT;
                    st_r <= H_EWAIT;
                end
                H_EWAIT: begin
                    if (bus.reg_rvalid) begin
                        usr_ext_rdata <= bus.reg_rdata;
                        usr_done <= 1'b1;
                        st_r <= H_IDLE;
                    end
                end
                default: begin
                    st_r <= H_IDLE;
                end
            endcase
        end
    end
endmodule

// *** verification/cpcp_sva.sv ***
// Purpose: Checks on the register pins between host and command port.
// Assumes: Both ends run on clk_sys.
// Notes: Busy as the host last saw it is rebuilt from its own reads.
`timescale 1ns/100ps
module cpcp_sva (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rst_b,
    // Register pins.
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [1:0] reg_sel,
    input wire logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire logic cp_start
);
    import cpcp_pkg::*;
    logic [1:0] rsel_r;
    logic busy_r;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) rsel_r <= 2'h0;
        else if (reg_rd) rsel_r <= reg_sel;
    end
    // A command write is taken as busy until a later read shows otherwise.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) busy_r <= 1'b0;
        else if (reg_wr && reg_sel == SEL_CMD) busy_r <= 1'b1;
        else if (reg_rvalid && rsel_r == SEL_CMD) busy_r <= reg_rdata[25];
    end
    sequence s_cmd_wr;
        reg_wr && reg_sel == SEL_CMD;
    endsequence
    sequence s_cmd_rd;
        reg_rd && reg_sel == SEL_CMD;
    endsequence
    property p_rvalid; reg_rd |=> reg_rvalid; endproperty
    a_rvalid: assert property (p_rvalid) else $error("no answer");
    property p_quiet;
        !reg_rd |=> !reg_rvalid && $stable(reg_rdata);
    endproperty
    a_quiet: assert property (p_quiet) else $error("read data moved");
    property p_busy;
        s_cmd_wr ##1 s_cmd_rd |=> reg_rdata[BUSY_BIT];
    endproperty
    a_busy: assert property (p_busy) else $error("busy not set");
    property p_wr_idle; s_cmd_wr |-> !busy_r; endproperty
    a_wr_idle: assert property (p_wr_idle) else $error("busy write");
    property p_ext_rd; reg_rd && reg_sel == SEL_EXT |-> !busy_r; endproperty
    a_ext_rd: assert property (p_ext_rd) else $error("early read");
    property p_err0; s_cmd_wr |-> !reg_wdata[ERR_BIT]; endproperty
    a_err0: assert property (p_err0) else $error("error bit sent");
    property p_pool;
        s_cmd_wr ##0 reg_wdata[31:26] == OP_ADDBUF |-> !reg_wdata[20:19];
    endproperty
    a_pool: assert property (p_pool) else $error("pool high bits");
    property p_align;
        s_cmd_wr ##0 reg_wdata[31:26] == OP_INDIR |-> reg_wdata[1:0] == 2'h0;
    endproperty
    a_align: assert property (p_align) else $error("unaligned address");
    property p_ext;
        reg_wr && reg_sel == SEL_EXT |=> ##[0:8] s_cmd_wr;
    endproperty
    a_ext: assert property (p_ext) else $error("no command after ext");
endmodule

// *** verification/cpcp_tb.sv ***
// Purpose: Drives host and device ends together through commands.
// Assumes: Memories are modelled by one-cycle ack pulses.
// Notes: Boot copy runs in full, so the run holds about 4300 cycles.
`timescale 1ns/100ps
`define CK(a, b) begin comparisons++; if ((a) !== (b)) begin error_cnt++; \
 $display("CHECK FAILED t=%0t %h %h", $time, a, b); end end
module cpcp_tb;
    import cpcp_pkg::*;
    int error_cnt = 0, comparisons = 0, n;
    logic clk_sys = 1'b0, rst_b = 1'b0, rf, ww, imem_ack = 1'b0;
    logic core_fetch_req = 1'b0, wram_ack = 1'b0, usr_init_req = 1'b0;
    logic usr_cmd_req = 1'b0, usr_use_ext = 1'b0, fetch_from_iram;
    logic core_stall, imem_req, iram_we, wram_req, wram_we, sched_start;
    logic pool_add, usr_ready, usr_done, usr_refused;
    logic [19:0] core_fetch_addr = 20'h00000;
    logic [31:0] imem_rdata = 32'h0, wram_rdata = 32'hCAFE_0001, wd;
    logic [31:0] usr_inbar = 32'h1000_0000, usr_ibbar = 32'h2000_0000;
    logic [31:0] usr_cmd_word = 32'h0, usr_ext_word = 32'h0, fetch_sys_addr;
    logic [31:0] imem_addr, iram_wdata, wram_wdata, shared_base, pool_ptr;
    logic [31:0] usr_ind_word, usr_ext_rdata;
    logic [10:0] iram_idx;
    logic [3:0] wram_be, wb;
    logic [18:0] wram_addr, wa;
    logic [25:0] link_rate_cfg;
    logic [5:0] sched_vc;
    logic [2:0] pool_num;
    logic [15:0] pool_cnt;
    cpcp_if bus();
    cpcp_dev i_cpcp_dev (.bus(bus.dev), .*);
    cpcp_host i_cpcp_host (.bus(bus.host), .*);
    cpcp_sva i_cpcp_sva (.clk_sys, .rst_b,
        .reg_wr(bus.reg_wr), .reg_rd(bus.reg_rd), .reg_sel(bus.reg_sel),
        .reg_wdata(bus.reg_wdata), .reg_rdata(bus.reg_rdata),
        .reg_rvalid(bus.reg_rvalid), .cp_start(bus.cp_start));
    always #2 clk_sys = ~clk_sys;
    // Every other cycle, so a held request gets one-cycle ack pulses.
    always @(posedge clk_sys) begin
        imem_ack <= imem_req && !imem_ack;
        wram_ack <= wram_req && !wram_ack;
        if (wram_req) begin
            {ww, wb, wa, wd} <= {wram_we, wram_be, wram_addr, wram_wdata};
        end
    end
    function automatic logic [31:0] vw(logic [5:0] op, logic [11:0] v);
        return {op, 8'h00, v, 6'h00};
    endfunction
    task cmd(logic [31:0] w, logic [31:0] e = 32'h0, logic u = 1'b0);
        rf = 1'b0;
        @(posedge clk_sys);
        {usr_cmd_word, usr_ext_word, usr_use_ext} <= {w, e, u};
        usr_cmd_req <= 1'b1;
        @(posedge clk_sys);
        usr_cmd_req <= 1'b0;
        for (n = 0; n < 300 && usr_done !== 1'b1 && rf !== 1'b1; n++) begin
            @(negedge clk_sys);
            rf = usr_refused;
        end
    endtask
    task end_sim;
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        #60000;
        error_cnt++;
        end_sim;
    end
    initial begin
        repeat (4) @(posedge clk_sys);
        rst_b <= 1'b1;
        usr_init_req <= 1'b1;
        @(posedge clk_sys) usr_init_req <= 1'b0;
        core_fetch_req <= 1'b1;
        for (n = 0; n < 5000 && core_stall !== 1'b0; n++) @(negedge clk_sys);
        `CK({core_stall, shared_base}, {1'b0, usr_ibbar})
        `CK({fetch_sys_addr, fetch_from_iram}, {usr_inbar, 1'b1})
        @(posedge clk_sys) core_fetch_addr <= 20'h02000;
        repeat (2) @(negedge clk_sys);
        `CK({fetch_sys_addr, fetch_from_iram}, {32'h1000_2000, 1'b0})
        cmd(vw(OP_TXRDY, 12'h001));
        `CK(rf, 1'b1)
        cmd({OP_LINK, 26'h0ABCDE});
        `CK({rf, link_rate_cfg}, {1'b0, 26'h0ABCDE})
        cmd({OP_LINK, 26'h0000011});
        `CK({rf, link_rate_cfg}, {1'b1, 26'h0ABCDE})
        for (int i = 1; i < 3; i++) begin
            cmd(vw(OP_OPEN, 12'h000));
            `CK(usr_ind_word[17:6], 12'(i))
        end
        cmd(vw(OP_TXRDY, 12'h001));
        `CK({usr_ind_word[24:6], sched_vc}, 25'h0000041)
        cmd(vw(OP_TXRDY, 12'h005));
        `CK(usr_ind_word[ERR_BIT], 1'b1)
        cmd(vw(OP_CLOSE, 12'h002));
        `CK(usr_ind_word[24:6], 19'h00002)
        cmd(vw(OP_CLOSE, 12'h002));
        `CK(usr_ind_word[24:6], 19'h40000)
        cmd({OP_ADDBUF, 10'h003, 16'hFFFF}, 32'h3000_0040, 1'b1);
        `CK(usr_ind_word[24:16], 9'h003)
        `CK({pool_num, pool_cnt, pool_ptr}, 51'h3_FFFF_3000_0040)
        cmd({OP_ADDBUF, 10'h003, 16'h0001}, 32'h3000_0080, 1'b1);
        `CK({usr_ind_word[24], pool_cnt}, 17'h1FFFF)
        cmd({OP_INDIR, 3'h0, 4'h5, 19'h01234}, 32'h1234_5678, 1'b1);
        `CK({ww, wb, wa, wd}, {1'b1, 4'h5, 19'h01234, 32'h1234_5678})
        cmd({OP_INDIR, 3'h1, 4'hF, 19'h00100});
        `CK({ww, wa, usr_ext_rdata}, {1'b0, 19'h00100, wram_rdata})
        end_sim;
    end
endmodule
